//--- dv/locator_partner.sv
// Model of the locator buttons and the management controller.
`timescale 1ns/1ns
module locator_partner (
	// Clock.
	input wire logic clk_i,
	// Pins toward the block.
	output logic [1:0] btn_o,
	output logic on_o,
	output logic off_o
);
	// All pins start released.
	initial begin
		btn_o = 2'h0;
		on_o = 1'b0;
		off_o = 1'b0;
	end
	// Held for eight cycles so the press outlasts the synchroniser.
	task automatic press(input logic [1:0] which);
		btn_o = which;
		repeat (8) @(posedge clk_i);
		#5 btn_o = 2'h0;
		repeat (8) @(posedge clk_i);
		#5;
	endtask
	// One-cycle request, activate when on is high, else deactivate.
	// An idle edge follows, so back-to-back calls never collide.
	task automatic remote(input logic on);
		on_o = on;
		off_o = !on;
		@(posedge clk_i);
		#5 on_o = 1'b0;
		off_o = 1'b0;
		@(posedge clk_i);
		#5;
	endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the locator indicator block.
`timescale 1ns/1ns
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] btn;
	logic on_req, off_req, led_f, led_r, active, remote;
	int err_count = 0;
	int checks = 0;
	logic en = 1'b1;
	// A short blink keeps the run brief.
	localparam int BLINK = 4;
	// Half of the 50 ns period.
	always #25 clk_i = ~clk_i;
	locator_partner far (.clk_i(clk_i), .btn_o(btn), .on_o(on_req),
		.off_o(off_req));
	system_locator_led_control #(.BLINK_CYC(BLINK)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .en_i(en), .btn_i(btn), .remote_on_i(on_req),
		.remote_off_i(off_req), .led_front_o(led_f), .led_rear_o(led_r),
		.active_o(active), .remote_o(remote));
	// Compares one value and counts it.
	task automatic chk(input string what, input logic seen, input logic exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// Prints the verdict and stops.
	task automatic tally_and_finish();
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Dark straight after reset.
	task automatic reset_dark();
		chk("led", led_f, 1'b0);
		chk("active", active, 1'b0);
	endtask
	// Both buttons at once count as one press; remote is ignored.
	task automatic button_steady();
		far.press(2'h3);
		chk("led", led_f, 1'b1);
		chk("rear led", led_r, 1'b1);
		chk("remote", remote, 1'b0);
		far.remote(1'b0);
		chk("led", led_f, 1'b1);
		far.remote(1'b1);
		chk("remote", remote, 1'b0);
		far.press(2'h2);
		chk("active", active, 1'b0);
		chk("rear led", led_r, 1'b0);
	endtask
	// Remote entry blinks at the set half period, ignores a press and
	// ends on remote off. The request edge counts as the first lit cycle.
	task automatic remote_blink();
		far.remote(1'b1);
		chk("remote", remote, 1'b1);
		chk("led", led_f, 1'b1);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_i);
			#5;
			chk("blink", led_f, ((i + 2) / BLINK) % 2 == 0);
			chk("led pair", led_r, led_f);
		end
		far.press(2'h1);
		chk("remote", remote, 1'b1);
		far.remote(1'b0);
		chk("active", active, 1'b0);
		chk("led", led_f, 1'b0);
	endtask
	// A press under a low enable is lost; the front button alone toggles.
	task automatic freeze_front();
		en = 1'b0;
		far.press(2'h1);
		chk("active", active, 1'b0);
		en = 1'b1;
		far.press(2'h1);
		chk("led", led_f, 1'b1);
		far.press(2'h1);
		chk("led", led_f, 1'b0);
	endtask
	// A reset in mid-run drops blinking back to dark; rear alone lights.
	task automatic reset_mid();
		far.remote(1'b1);
		chk("remote", remote, 1'b1);
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#5 rst_i = 1'b0;
		chk("led", led_f, 1'b0);
		chk("remote", remote, 1'b0);
		far.press(2'h2);
		chk("led", led_f, 1'b1);
	endtask
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_i);
		#5 rst_i = 1'b0;
		reset_dark();
		button_steady();
		remote_blink();
		freeze_front();
		reset_mid();
		tally_and_finish();
	end
endmodule

//--- rtl/button_sync.sv
// Synchroniser and press detector for the two locator buttons.
`timescale 1ns/1ns
module button_sync
	import locator_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	// Raw active-high button levels.
	input wire logic [1:0] btn_i,
	// Press events.
	press_if.source ev
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] level;
	} state_s;
	state_s q;
	state_s next_q;
	logic [1:0] rise;

	// A level changes only once stages two and three agree.
	always_comb begin
		next_q = q;
		rise = 2'h0;
		if (en_i) begin
			next_q.s1 = btn_i;
			next_q.s2 = q.s1;
			next_q.s3 = q.s2;
			for (int i = 0; i < 2; i++) begin
				if (q.s2[i] == q.s3[i]) begin
					next_q.level[i] = q.s3[i];
					rise[i] = q.s3[i] & ~q.level[i];
				end
			end
		end
	end

	// Either button counts as a press.
	assign ev.press = |rise;

	// State register.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule

//--- rtl/locator_pkg.sv
// Shared constants and types for the system locator indicator block.
package locator_pkg;
	// Indicator mode, one-hot.
	typedef enum logic [2:0] {
		MODE_DARK = 3'h1,
		MODE_BUTTON = 3'h2,
		MODE_REMOTE = 3'h4
	} mode_e;
	// Blink half period in microseconds and derived clock cycles at 20 MHz.
	localparam int CLK_HZ = 20000000;
	localparam int BLINK_HALF_US = 500000;
	localparam int BLINK_HALF_CYC = (BLINK_HALF_US / 1000) * (CLK_HZ / 1000);
	// Width of the blink counter.
	localparam int BLINK_W = 24;
	// Number of flip-flops in the pin input synchroniser.
	localparam int SYNC_STAGES = 3;
endpackage

//--- rtl/press_if.sv
// Interface carrying cleaned press events from the button synchroniser.
`timescale 1ns/1ns
interface press_if;
	logic press;
	modport source (output press);
	modport sink (input press);
endinterface

//--- rtl/system_locator_led_control.sv
// Top of the system locator indicator block.
`timescale 1ns/1ns
// Summary of operation
// - Dark, steady or blinking by activation source.
// - Button press toggles dark and steady.
// - Steady mode ignores remote deactivation.
// - Blinking mode ignores button presses.
// - Both buttons equal, both LEDs together.
// - Enter from dark by button or remote.
module system_locator_led_control
	import locator_pkg::*;
#(
	parameter int BLINK_CYC = BLINK_HALF_CYC
) (
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	// Buttons, front in bit 0, rear in bit 1.
	input wire logic [1:0] btn_i,
	// Remote one-cycle requests from the management logic.
	input wire logic remote_on_i,
	input wire logic remote_off_i,
	// Locator LEDs, front and rear, and mode flags.
	output logic led_front_o,
	output logic led_rear_o,
	output logic active_o,
	output logic remote_o
);
	typedef struct packed {
		mode_e mode;
		logic [BLINK_W-1:0] cnt;
		logic phase;
		logic led;
	} state_s;
	state_s q;
	state_s next_q;
	press_if pif ();

	// Wrap test of the blink counter, shared by the logic and its checks.
	function automatic logic blink_wrap(input logic [BLINK_W-1:0] cnt);
		return cnt >= BLINK_W'(BLINK_CYC - 1);
	endfunction

	// Press detection lives in its own module.
	button_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(en_i),
		.btn_i(btn_i),
		.ev(pif.source)
	);

	// Mode transitions, blink timing and LED level.
	always_comb begin
		next_q = q;
		if (en_i) begin
			case (q.mode)
				MODE_DARK: begin
					// A press in the same cycle as a remote request wins.
					if (pif.press) begin
						next_q.mode = MODE_BUTTON;
					end else if (remote_on_i) begin
						next_q.mode = MODE_REMOTE;
					end
				end
				MODE_BUTTON: begin
					// Remote requests have no effect here.
					if (pif.press) begin
						next_q.mode = MODE_DARK;
					end
				end
				MODE_REMOTE: begin
					// Presses are ignored; only remote may end it.
					if (remote_off_i) begin
						next_q.mode = MODE_DARK;
					end
				end
				default: begin
					next_q.mode = MODE_DARK;
				end
			endcase
			// The counter runs only in remote mode and is parked at zero
			// elsewhere, so every activation sees a full first half period.
			if (q.mode == MODE_REMOTE) begin
				if (blink_wrap(q.cnt)) begin
					next_q.cnt = '0;
					next_q.phase = ~q.phase;
				end else begin
					next_q.cnt = q.cnt + 1'b1;
				end
			end else begin
				// Blinking restarts lit on each remote activation.
				next_q.cnt = '0;
				next_q.phase = 1'b1;
			end
			case (next_q.mode)
				MODE_BUTTON: next_q.led = 1'b1;
				MODE_REMOTE: next_q.led = next_q.phase;
				default: next_q.led = 1'b0;
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{mode: MODE_DARK, cnt: '0, phase: 1'b1, led: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	// Both LEDs show one indication.
	assign led_front_o = q.led;
	assign led_rear_o = q.led;
	// Flags decode the registered mode, so they cannot glitch.
	assign active_o = (q.mode != MODE_DARK);
	assign remote_o = (q.mode == MODE_REMOTE);

	// Steady mode keeps both LEDs lit.
	a_button_steady: assert property (
		@(posedge clk_i) disable iff (rst_i)
		q.mode == MODE_BUTTON |-> led_front_o && led_rear_o)
		else $error("LED not steady in button mode");

	// Dark mode keeps both LEDs off.
	a_dark_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		q.mode == MODE_DARK |-> !led_front_o && !led_rear_o)
		else $error("LED lit while inactive");

	// Only the three one-hot modes can ever be held.
	a_mode_onehot: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$onehot(q.mode))
		else $error("Mode register not one-hot");

	// Remote mode implies that the block reads as active.
	a_status_pair: assert property (
		@(posedge clk_i) disable iff (rst_i)
		remote_o |-> active_o)
		else $error("Remote flag without active flag");

	// A press in dark mode lights the LEDs on the next edge.
	sequence s_dark_press;
		en_i && q.mode == MODE_DARK && pif.press;
	endsequence
	a_press_on: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_dark_press |=> q.mode == MODE_BUTTON && led_front_o)
		else $error("Press did not light LEDs");

	// A press in button mode turns the LEDs dark again.
	sequence s_button_press;
		en_i && q.mode == MODE_BUTTON && pif.press;
	endsequence
	a_press_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_button_press |=> q.mode == MODE_DARK && !led_front_o)
		else $error("Second press did not darken LEDs");

	// Button mode is left by a press and by nothing else.
	a_remote_ignored: assert property (
		@(posedge clk_i) disable iff (rst_i)
		q.mode == MODE_BUTTON && !pif.press |=> q.mode == MODE_BUTTON)
		else $error("Button mode left without press");

	// Remote mode is left by a remote release and by nothing else.
	a_press_ignored: assert property (
		@(posedge clk_i) disable iff (rst_i)
		q.mode == MODE_REMOTE && !remote_off_i |=> q.mode == MODE_REMOTE)
		else $error("Remote mode left without remote off");

	// Front and rear LEDs always agree.
	a_leds_equal: assert property (
		@(posedge clk_i) disable iff (rst_i)
		led_front_o == led_rear_o)
		else $error("Front and rear LEDs differ");

	// Dark mode is left only by a press or a remote activation.
	a_dark_stays: assert property (
		@(posedge clk_i) disable iff (rst_i)
		q.mode == MODE_DARK && !pif.press && !remote_on_i
		|=> q.mode == MODE_DARK)
		else $error("Dark mode left without a request");

	// A remote activation in dark mode starts blinking, lit first.
	a_remote_on: assert property (
		@(posedge clk_i) disable iff (rst_i)
		en_i && q.mode == MODE_DARK && !pif.press && remote_on_i
		|=> remote_o && led_front_o)
		else $error("Remote activation not taken");

	// A remote release in remote mode goes dark on the next edge.
	sequence s_remote_off;
		en_i && q.mode == MODE_REMOTE && remote_off_i;
	endsequence
	a_remote_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_remote_off |=> q.mode == MODE_DARK && !led_front_o)
		else $error("Remote deactivation not taken");

	// A low enable freezes every state bit, the blink counter included.
	a_enable_freeze: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!en_i |=> $stable(q))
		else $error("State moved while enable was low");

	// The LEDs flip exactly when the blink counter wraps.
	sequence s_blink_wrap;
		en_i && q.mode == MODE_REMOTE && !remote_off_i && blink_wrap(q.cnt);
	endsequence
	a_blink_toggle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_blink_wrap |=> $changed(led_front_o))
		else $error("LEDs did not flip at the half period");

	// Between wraps the blinking LEDs hold their level.
	sequence s_blink_run;
		en_i && q.mode == MODE_REMOTE && !remote_off_i && !blink_wrap(q.cnt);
	endsequence
	a_blink_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_blink_run |=> $stable(led_front_o) && remote_o)
		else $error("LEDs moved inside a half period");
endmodule
